/* File: src/amp_pwm_pin_config.sv */
// Pin-configured PWM output stage with bridge mode, soft clip and sleep.
`timescale 1ns/10ps
`include "amp_pwm_cfg.svh"
module amp_pwm_pin_config
  import amp_pwm_pkg::*;
(
  input  wire logic              i_clock,                // 20 MHz system clock.
  input  wire logic              i_rst_n,                // Synchronous reset, active low.
  input  wire logic              i_serial_audio_in,      // Serial audio data pin.
  input  wire logic              i_bit_clock,            // Serial bit clock pin.
  input  wire logic              i_frame_channel_select, // Frame channel select pin.
  input  wire logic              i_carrier_rate_select,  // High: eight, low: sixteen per sample.
  input  wire logic              i_bridge_pair_select,   // High: paralleled mono mode.
  input  wire logic              i_amp_sleep_request,    // High: stop output switching.
  input  wire logic [1:0]        i_amp_gain_pins,        // Both high: software control.
  input  wire logic [`CNT_W-1:0] i_soft_clip_level,      // Maximum duty, sampled at reset.
  output logic                   o_pwm_a,                // Channel A PWM output.
  output logic                   o_pwm_b,                // Channel B PWM output.
  output logic                   o_out_en_n,             // Output stage enable, low drives.
  output logic                   o_pin_mode,             // High while in pin control mode.
  output logic                   o_paralleled_mono_mode, // Applied bridge mode.
  output logic                   o_carrier_slow          // Applied carrier rate.
);
  ////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [7:0]        sync1_q;
  logic [7:0]        sync2_q;
  logic [`CNT_W-1:0] clip_s1_q;
  logic [`CNT_W-1:0] clip_s2_q;
  logic [`CNT_W-1:0] clip_max_q;
  logic              reset_seen_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_carrier_rate_select, i_bridge_pair_select, i_amp_gain_pins,
                  i_amp_sleep_request, i_serial_audio_in, i_frame_channel_select,
                  i_bit_clock};
      sync2_q <= sync1_q;
    end
  end

  // The clip level keeps running through its flops during reset, so the level held in reset is
  // the one captured.
  always_ff @(posedge i_clock) begin
    clip_s1_q <= i_soft_clip_level;
    clip_s2_q <= clip_s1_q;
  end

  logic sleep_s;
  logic pin_mode;
  logic rate_s;
  logic bridge_s;
  assign sleep_s  = sync2_q[3];
  assign pin_mode = ~(sync2_q[5] & sync2_q[4]);
  assign rate_s   = sync2_q[7];
  assign bridge_s = sync2_q[6];

  // Captured on the first edge after reset is released.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      reset_seen_q <= 1'b0;
      clip_max_q   <= `CLIP_FULL;
    end else if (!reset_seen_q) begin
      reset_seen_q <= 1'b1;
      clip_max_q   <= clip_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // Audio capture runs regardless of sleep.
  logic [`SAMPLE_W-1:0] left_w;
  logic [`SAMPLE_W-1:0] right_w;
  logic                 frame_w;

  audio_frame_rx u_rx (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_bit_clk    (sync2_q[0]),
    .i_frame_sel  (sync2_q[1]),
    .i_data       (sync2_q[2]),
    .o_left       (left_w),
    .o_right      (right_w),
    .o_frame_done (frame_w)
  );

  ////////////////////////////////////////////////////////////////////////////////////
  // Output state and mode latching.
  out_state_e state_q;
  logic       mono_q;
  logic       slow_q;
  logic       period_end;
  logic       stop_req;
  logic       len_ok_q;

  assign stop_req = sleep_s | ~pin_mode;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_RUN:      if (stop_req) state_q <= ST_STOPPING;
        ST_STOPPING: if (period_end) state_q <= ST_IDLE;
        ST_IDLE:     if (!stop_req && frame_w && len_ok_q) state_q <= ST_RUN;
        default:     state_q <= ST_IDLE;
      endcase
    end
  end

  // Mode pins are read only while idle so a period is never cut.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mono_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (state_q == ST_IDLE && pin_mode) begin
      mono_q <= bridge_s;
      slow_q <= rate_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // Carrier: sixteen or eight PWM periods per audio frame.
  logic [`CNT_W-1:0]   pos_q;
  logic [`CNT_W-1:0]   per_len;
  logic [`CNT_W-1:0]   duty_a_q;
  logic [`CNT_W-1:0]   duty_b_q;
  logic [`CNT_W-1:0]   raw_a;
  logic [`CNT_W-1:0]   raw_b;
  logic [`CNT_W-1:0]   clip_a;
  logic [`CNT_W-1:0]   clip_b;
  logic [`CNT_W-1:0]   frame_cnt_q;
  logic [`CNT_W-1:0]   period_cyc_q;
  logic [2*`CNT_W-1:0] prod_a;
  logic [2*`CNT_W-1:0] prod_b;
  logic [`CNT_W-1:0]   hi_a;
  logic [`CNT_W-1:0]   hi_b;

  // Frame length in clocks sets the period length, so the carrier follows the sample rate.
  // The first count after reset starts at an arbitrary point, so switching waits for a second.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      frame_cnt_q  <= '0;
      period_cyc_q <= '0;
      len_ok_q     <= 1'b0;
    end else if (frame_w) begin
      frame_cnt_q  <= '0;
      period_cyc_q <= frame_cnt_q;
      len_ok_q     <= 1'b1;
    end else if (frame_cnt_q != `CLIP_FULL) begin
      frame_cnt_q <= frame_cnt_q + `CNT_W'(1);
    end
  end

  // Last clock index of one carrier period: a sixteenth or an eighth of the frame.
  assign per_len    = slow_q ? (period_cyc_q >> $clog2(`CARRIER_SLOW))
                             : (period_cyc_q >> $clog2(`CARRIER_FAST));
  assign period_end = (pos_q >= per_len);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || state_q == ST_IDLE) begin
      pos_q <= '0;
    end else if (period_end) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_q + `CNT_W'(1);
    end
  end

  // High time in clocks is the duty fraction of the period length.
  assign prod_a = {`CNT_W'(0), duty_a_q} * {`CNT_W'(0), per_len + `CNT_W'(1)};
  assign prod_b = {`CNT_W'(0), duty_b_q} * {`CNT_W'(0), per_len + `CNT_W'(1)};
  assign hi_a   = prod_a[2*`CNT_W-1 -: `CNT_W];
  assign hi_b   = prod_b[2*`CNT_W-1 -: `CNT_W];

  // Signed sample to offset binary duty.
  assign raw_a = (mono_q ? right_w[`SAMPLE_W-1 -: `CNT_W] : left_w[`SAMPLE_W-1 -: `CNT_W])
                 ^ `DUTY_HALF;
  assign raw_b = right_w[`SAMPLE_W-1 -: `CNT_W] ^ `DUTY_HALF;
  assign clip_a = (raw_a > clip_max_q) ? clip_max_q : raw_a;
  assign clip_b = (raw_b > clip_max_q) ? clip_max_q : raw_b;

  // Duty is reloaded at a period boundary, and on every clock while idle.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      duty_a_q <= `DUTY_HALF;
      duty_b_q <= `DUTY_HALF;
    end else if (period_end || state_q == ST_IDLE) begin
      duty_a_q <= clip_a;
      duty_b_q <= mono_q ? clip_a : clip_b;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pwm_a                <= 1'b0;
      o_pwm_b                <= 1'b0;
      o_out_en_n             <= 1'b1;
      o_pin_mode             <= 1'b1;
      o_paralleled_mono_mode <= 1'b0;
      o_carrier_slow         <= 1'b0;
    end else begin
      o_pwm_a                <= (state_q != ST_IDLE) && (pos_q < hi_a);
      o_pwm_b                <= (state_q != ST_IDLE) && (pos_q < hi_b);
      o_out_en_n             <= (state_q == ST_IDLE);
      o_pin_mode             <= pin_mode;
      o_paralleled_mono_mode <= mono_q;
      o_carrier_slow         <= slow_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_mono_same_out: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_paralleled_mono_mode |-> (o_pwm_a == o_pwm_b))
    else $error("paralleled outputs differ");
  a_idle_no_switch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_out_en_n |-> (!o_pwm_a && !o_pwm_b))
    else $error("switching while disabled");
  a_mode_hold_run: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q != ST_IDLE) |=> $stable(mono_q) && $stable(slow_q))
    else $error("mode changed while switching");
  a_clip_duty_cap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    reset_seen_q |-> (duty_a_q <= clip_max_q || $past(state_q) == ST_IDLE))
    else $error("duty above clip limit");
  a_sleep_stops: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == ST_RUN && stop_req) |=> state_q == ST_STOPPING)
    else $error("sleep not honoured");
  a_soft_mode_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!pin_mode && state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("switching outside pin mode");
endmodule

/* File: src/amp_pwm_cfg.svh */
// Constants for the pin-configured PWM output stage.
`ifndef AMP_PWM_CFG_SVH
`define AMP_PWM_CFG_SVH
`define SAMPLE_W        16
`define CARRIER_FAST    16
`define CARRIER_SLOW    8
`define CNT_W           8
`define CLIP_FULL       8'hFF
`define CLIP_DIV        4
`define DUTY_HALF       8'h80
`endif

/* File: src/amp_pwm_pkg.sv */
// Types shared by the PWM output stage files.
package amp_pwm_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOPPING,
    ST_IDLE
  } out_state_e;
endpackage

/* File: src/audio_frame_rx.sv */
// Serial audio receiver that captures left and right samples of each frame.
`timescale 1ns/10ps
`include "amp_pwm_cfg.svh"
module audio_frame_rx (
  input  wire logic                 i_clock,      // System clock.
  input  wire logic                 i_rst_n,      // Synchronous reset, active low.
  input  wire logic                 i_bit_clk,    // Synchronised bit clock.
  input  wire logic                 i_frame_sel,  // Synchronised frame channel select.
  input  wire logic                 i_data,       // Synchronised serial audio data.
  output logic [`SAMPLE_W-1:0]      o_left,       // Last left sample.
  output logic [`SAMPLE_W-1:0]      o_right,      // Last right sample.
  output logic                      o_frame_done  // Pulse when a right sample lands.
);
  logic                 bclk_q;
  logic                 sel_q;
  logic [`SAMPLE_W-1:0] shift_q;
  logic                 rise;

  assign rise = i_bit_clk & ~bclk_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bclk_q       <= 1'b0;
      sel_q        <= 1'b0;
      shift_q      <= '0;
      o_left       <= '0;
      o_right      <= '0;
      o_frame_done <= 1'b0;
    end else begin
      bclk_q       <= i_bit_clk;
      o_frame_done <= 1'b0;
      if (rise) begin
        sel_q   <= i_frame_sel;
        shift_q <= {shift_q[`SAMPLE_W-2:0], i_data};
        // The last bit of a word arrives with the changed select, so it is included here.
        if (sel_q != i_frame_sel) begin
          if (sel_q) begin
            o_right      <= {shift_q[`SAMPLE_W-2:0], i_data};
            o_frame_done <= 1'b1;
          end else begin
            o_left <= {shift_q[`SAMPLE_W-2:0], i_data};
          end
        end
      end
    end
  end
endmodule

/* File: bench/audio_host_model.sv */
// Serial audio sender that stands in for the host processor.
`timescale 1ns/10ps
module audio_host_model (
  input  wire logic        i_clock, // System clock.
  input  wire logic        i_run,   // High: frames are sent.
  input  wire logic        i_swap,  // High: channel select inverted.
  input  wire logic [15:0] i_left,  // Left sample.
  input  wire logic [15:0] i_right, // Right sample.
  output logic             o_bclk,  // Bit clock.
  output logic             o_fsel,  // Frame channel select.
  output logic             o_data   // Serial data.
);
  logic [2:0]  phase_q = 3'h0;
  logic [4:0]  bit_q   = 5'h0;
  logic [31:0] word;
  assign word = {i_left, i_right};
  initial begin
    o_bclk = 1'b0;
    o_fsel = 1'b0;
    o_data = 1'b0;
  end
  // The bit clock stands still between streams and the data line toggles.
  always @(posedge i_clock) begin
    if (!i_run) begin
      o_bclk <= 1'b0;
      o_data <= ~o_data;
      phase_q <= 3'h0;
      bit_q <= 5'h0;
    end else begin
      phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
      if (phase_q == 3'h0) begin
        o_bclk <= 1'b0;
        o_fsel <= (bit_q >= 5'h10) ^ i_swap;
        o_data <= word[5'h1F - (bit_q - 5'h1)];
        bit_q <= bit_q + 5'h1;
      end
      if (phase_q == 3'h3) begin
        o_bclk <= 1'b1;
      end
    end
  end
endmodule

/* File: bench/amp_pwm_pin_config_tb.sv */
// Self-checking bench for the pin-configured PWM output stage.
`timescale 1ns/10ps
module amp_pwm_pin_config_tb;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        rate = 1'b0, bridge = 1'b0, sleep = 1'b0, run = 1'b0, swap = 1'b0;
  logic [1:0]  gain = 2'h0;
  logic [7:0]  clip = 8'hFF;
  logic [15:0] left = 16'h4000, right = 16'hC000;
  logic        bclk, fsel, sdat, pwm_a, pwm_b, en_n, pin_mode, mono, slow, pa;
  int          fail_count = 0, checked = 0, a_hi, b_hi, rises, diffs;
  always #25 i_clock = ~i_clock;
  audio_host_model u_host (.i_clock(i_clock), .i_run(run), .i_swap(swap), .i_left(left),
    .i_right(right), .o_bclk(bclk), .o_fsel(fsel), .o_data(sdat));
  amp_pwm_pin_config u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_audio_in(sdat),
    .i_bit_clock(bclk), .i_frame_channel_select(fsel), .i_carrier_rate_select(rate),
    .i_bridge_pair_select(bridge), .i_amp_sleep_request(sleep), .i_amp_gain_pins(gain),
    .i_soft_clip_level(clip), .o_pwm_a(pwm_a), .o_pwm_b(pwm_b), .o_out_en_n(en_n),
    .o_pin_mode(pin_mode), .o_paralleled_mono_mode(mono), .o_carrier_slow(slow));
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #5;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_near(input int got, input int exp, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_en(input logic val, input int limit);
    int n;
    n = 0;
    while (en_n !== val && n < limit) begin
      tick(1);
      n++;
    end
    check_bit(en_n, val);
  endtask
  // Four frames of 192 clocks hold 64 fast or 32 slow carrier periods.
  task automatic measure();
    a_hi = 0;
    b_hi = 0;
    rises = 0;
    diffs = 0;
    repeat (768) begin
      pa = pwm_a;
      tick(1);
      if (pwm_a === 1'b1) a_hi++;
      if (pwm_b === 1'b1) b_hi++;
      if (pwm_a === 1'b1 && pa === 1'b0) rises++;
      if (pwm_a !== pwm_b) diffs++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    check_bit(pwm_a | pwm_b, 1'b0);
    check_bit(en_n, 1'b1);
    check_bit(pin_mode, 1'b1);
    check_bit(mono | slow, 1'b0);
    i_rst_n = 1'b1;
    run = 1'b1;
    wait_en(1'b0, 800);
    measure();
    check_near(rises, 64, 2);
    check_near(a_hi, 576, 72);
    check_near(b_hi, 192, 72);
    $display("stereo fast test done");
    rate = 1'b1;
    bridge = 1'b1;
    tick(20);
    check_bit(slow | mono, 1'b0);
    sleep = 1'b1;
    wait_en(1'b1, 100);
    check_bit(pwm_a | pwm_b, 1'b0);
    tick(5);
    check_bit(slow, 1'b1);
    check_bit(mono, 1'b1);
    tick(400);
    sleep = 1'b0;
    wait_en(1'b0, 400);
    measure();
    check_near(rises, 32, 2);
    check_near(diffs, 0, 0);
    check_near(a_hi, 192, 72);
    $display("mono slow test done");
    swap = 1'b1;
    tick(600);
    measure();
    check_near(a_hi, 576, 72);
    $display("swapped select test done");
    sleep = 1'b1;
    wait_en(1'b1, 100);
    run = 1'b0;
    gain = 2'h3;
    tick(10);
    check_bit(pin_mode, 1'b0);
    check_bit(en_n, 1'b1);
    $display("control handover test done");
    i_rst_n = 1'b0;
    {gain, rate, bridge, sleep, swap} = 6'h00;
    clip = 8'h60;
    left = 16'h7F00;
    tick(10);
    i_rst_n = 1'b1;
    tick(1);
    clip = 8'hFF;
    run = 1'b1;
    wait_en(1'b0, 800);
    measure();
    check_near(a_hi, 288, 72);
    $display("soft clip test done");
    final_report();
  end
endmodule
